// >>> dv/tb_vpa_arb_table.sv
// Purpose: self-checking bench for the vc port arbitration table
// Assumes: classic wishbone, one request at a time, upstream port first
// Notes:   reserved codes are programmed on purpose to exercise phase skipping
`timescale 1ns/100ps
module tb_vpa_arb_table;
	logic        clk_i, rst_i, is_upstream_i, flow_init_pending_i;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [2:0]  grant_port_o;
	logic [4:0]  grant_phase_o;
	int          errors, compares, i;
	logic [11:0] ofs [6]    = '{vpa_pkg::OFS_CONTROL, vpa_pkg::OFS_STATUS, vpa_pkg::OFS_TBL0,
	                            vpa_pkg::OFS_TBL1, vpa_pkg::OFS_TBL2, vpa_pkg::OFS_TBL3};
	logic [4:0]  exp_ph [3] = '{5'h00, 5'h02, 5'h0C};
	logic [2:0]  exp_pt [3] = '{vpa_pkg::GRANT_P2, vpa_pkg::GRANT_P4, vpa_pkg::GRANT_UP};

	vpa_arb_table uut (.clk_i(clk_i), .rst_i(rst_i), .is_upstream_i(is_upstream_i),
		.flow_init_pending_i(flow_init_pending_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .grant_port_o(grant_port_o),
		.grant_phase_o(grant_phase_o));

	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// one classic cycle, entered right after a rising edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		check("ack", wb_ack_o, 32'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i  <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'h1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [11:0] a);
		xfer(1'h0, a, 32'h0, 4'hF);
	endtask

	initial begin
		rst_i = 1'h1;
		is_upstream_i = 1'h1;
		flow_init_pending_i = 1'h0;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 12'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		errors = 0;
		compares = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (i = 0; i < 6; i++) begin
			rd(ofs[i]);
			check("reset value", q, 32'h0);
		end
		check("grant idle", grant_port_o, 32'h0);
		rd(12'h300);
		check("unmapped", q, 32'h0);
		wr(vpa_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rd(vpa_pkg::OFS_STATUS);
		check("status write", q, 32'h0);
		wr(vpa_pkg::OFS_TBL0, 32'h4204_2040);
		rd(vpa_pkg::OFS_TBL0);
		check("word 0", q, 32'h4204_2040);
		rd(vpa_pkg::OFS_STATUS);
		check("flag set", q, 32'h0001_0000);
		wr(vpa_pkg::OFS_TBL1, 32'h2044_2202);
		xfer(1'h1, vpa_pkg::OFS_TBL1, 32'h0002_0000, 4'h4);
		rd(vpa_pkg::OFS_TBL1);
		check("word 1", q, 32'h2002_2202);
		// phase 0 port 2, phase 2 port 4, phase 12 upstream, all others reserved
		wr(vpa_pkg::OFS_TBL0, 32'hFFFF_F4F2);
		wr(vpa_pkg::OFS_TBL1, 32'hFFF0_FFFF);
		wr(vpa_pkg::OFS_TBL2, 32'hFFFF_FFFF);
		wr(vpa_pkg::OFS_TBL3, 32'hFFFF_FFFF);
		flow_init_pending_i <= 1'h1;
		wr(vpa_pkg::OFS_CONTROL, 32'h0007_0000);
		rd(vpa_pkg::OFS_CONTROL);
		check("control", q, 32'h0006_0000);
		i = 0;
		do begin
			rd(vpa_pkg::OFS_STATUS);
			i++;
		end while (q[16] !== 1'h0 && i < 10);
		check("status loaded", q, 32'h0002_0000);
		wr(vpa_pkg::OFS_TBL0, 32'h0000_0004);
		rd(vpa_pkg::OFS_STATUS);
		check("flag again", q, 32'h0003_0000);
		i = 0;
		while (!(grant_phase_o === 5'h00 && grant_port_o !== 3'h0) && i < 80) begin
			@(posedge clk_i);
			i++;
		end
		for (i = 0; i < 6; i++) begin
			check("grant phase", grant_phase_o, exp_ph[i % 3]);
			check("grant port", grant_port_o, exp_pt[i % 3]);
			@(posedge clk_i);
		end
		is_upstream_i <= 1'h0;
		wr(vpa_pkg::OFS_TBL1, 32'h0);
		rd(vpa_pkg::OFS_STATUS);
		check("downstream flag", q[16], 32'h0);
		finish_test;
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		finish_test;
	end
endmodule

// >>> rtl/vpa_arb_table.sv
// Function
// - A software write to any table entry sets the coherency flag in status bit 16.
// - The coherency flag stays set until the load that follows a load command has finished.
// - On a downstream port the coherency flag always reads zero.
// - The coherency flag is only significant while the selected scheme uses the table.
// - Status bit 17 reports that flow control initialisation is still pending.
// - Table word 0 holds phases 0 to 7, each a 4-bit read-write port id at bits 4n+3:4n.
// - Table word 1 holds phases 8 to 15 at nibble n-8, so phase 12 sits at 19:16.
// - Port id 0x0 names the upstream port, 0x2 port 2, 0x4 port 4; all other codes are reserved.
// - A phase naming no valid port is skipped at once with no arbitration time spent.
// - After reset every phase holds 0x0, selecting the upstream port.
// - Writing one to control bit 16 requests a table load, zero does nothing, it reads zero, upstream only.
// - Phases 16 to 31 continue the same layout in table words 2 and 3 and are arbitrated too.
//
// Purpose: port arbitration table, its status and its phase walker for one vc resource
// Assumes: wishbone classic slave, one cycle of wait then ack; core clock and synchronous reset
// Notes:   unmapped addresses ack with zero read data and no effect
`timescale 1ns/100ps
module vpa_arb_table (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 is_upstream_i,
	input  wire logic                 flow_init_pending_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [11:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	output logic      [2:0]           grant_port_o,
	output logic      [4:0]           grant_phase_o
);
	vpa_pkg::vpa_state_t  st_r;
	vpa_pkg::vpa_state_t  st_nxt;
	vpa_pkg::vpa_wb_req_t req;
	logic                 flow_r;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [2:0] port_of(input logic [3:0] id);
		logic [2:0] g;
		g = vpa_pkg::GRANT_NONE;
		if (id == vpa_pkg::PORT_UP) begin
			g = vpa_pkg::GRANT_UP;
		end else if (id == vpa_pkg::PORT_2) begin
			g = vpa_pkg::GRANT_P2;
		end else if (id == vpa_pkg::PORT_4) begin
			g = vpa_pkg::GRANT_P4;
		end
		return g;
	endfunction

	function automatic logic [3:0] slot_of(input logic [vpa_pkg::NUM_WORDS-1:0][31:0] t, input logic [4:0] p);
		return t[p[4:3]][p[2:0]*vpa_pkg::SLOT_W +: vpa_pkg::SLOT_W];
	endfunction

	function automatic logic uses_table(input logic [2:0] s);
		return vpa_pkg::SCHEME_TBL_MASK[s];
	endfunction

	logic        access;
	logic        wr;
	logic        tbl_hit;
	logic [1:0]  tbl_sel;
	logic [31:0] status_word;
	logic [4:0]  p;
	logic [2:0]  g;

	always_comb begin
		st_nxt  = st_r;
		access  = req.cyc && req.stb && !st_r.ack;
		wr      = access && req.we;
		tbl_hit = 1'b0;
		tbl_sel = 2'h0;
		p       = st_r.phase;
		g       = vpa_pkg::GRANT_NONE;
		status_word = '0;
		status_word[vpa_pkg::BIT_COHERENT] = st_r.coherent && is_upstream_i;
		status_word[vpa_pkg::BIT_FLOWINIT] = flow_r;

		if (req.adr == vpa_pkg::OFS_TBL0) begin
			tbl_hit = 1'b1;
			tbl_sel = 2'h0;
		end else if (req.adr == vpa_pkg::OFS_TBL1) begin
			tbl_hit = 1'b1;
			tbl_sel = 2'h1;
		end else if (req.adr == vpa_pkg::OFS_TBL2) begin
			tbl_hit = 1'b1;
			tbl_sel = 2'h2;
		end else if (req.adr == vpa_pkg::OFS_TBL3) begin
			tbl_hit = 1'b1;
			tbl_sel = 2'h3;
		end

		st_nxt.ack  = access;
		st_nxt.rdat = '0;
		if (access && !req.we) begin
			if (req.adr == vpa_pkg::OFS_STATUS) begin
				st_nxt.rdat = status_word;
			end else if (req.adr == vpa_pkg::OFS_CONTROL) begin
				st_nxt.rdat[vpa_pkg::SEL_HI:vpa_pkg::SEL_LO] = st_r.scheme;
			end else if (tbl_hit) begin
				st_nxt.rdat = st_r.tbl[tbl_sel];
			end
		end

		// load walker: copies one word per cycle into the live copy
		case (st_r.ld_state)
			vpa_pkg::LD_IDLE: begin
			end
			vpa_pkg::LD_COPY: begin
				st_nxt.live[st_r.ld_idx] = st_r.tbl[st_r.ld_idx];
				st_nxt.ld_idx = st_r.ld_idx + 2'h1;
				if (st_r.ld_idx == 2'(vpa_pkg::NUM_WORDS - 1)) begin
					st_nxt.ld_state = vpa_pkg::LD_IDLE;
					st_nxt.coherent = 1'b0;
				end
			end
			default: st_nxt.ld_state = vpa_pkg::LD_IDLE;
		endcase

		if (wr && tbl_hit) begin
			st_nxt.tbl[tbl_sel] = merge_bytes(st_r.tbl[tbl_sel], req.dat, req.sel);
			st_nxt.coherent = 1'b1;
		end
		if (wr && req.adr == vpa_pkg::OFS_CONTROL) begin
			if (req.sel[2]) begin
				st_nxt.scheme = req.dat[vpa_pkg::SEL_HI:vpa_pkg::SEL_LO];
				if (req.dat[vpa_pkg::BIT_LOAD] && is_upstream_i) begin
					st_nxt.ld_state = vpa_pkg::LD_COPY;
					st_nxt.ld_idx   = 2'h0;
				end
			end
		end

		// phase walker over the live copy
		st_nxt.grant = vpa_pkg::GRANT_NONE;
		if (uses_table(st_r.scheme) && st_r.ld_state == vpa_pkg::LD_IDLE) begin
			for (int k = 0; k < vpa_pkg::NUM_PHASES; k++) begin
				if (g == vpa_pkg::GRANT_NONE) begin
					p = 5'(st_r.phase + 5'(k));
					g = port_of(slot_of(st_r.live, p));
				end
			end
			st_nxt.grant = g;
			if (g != vpa_pkg::GRANT_NONE) begin
				st_nxt.phase  = 5'(p + 5'h1);
				st_nxt.gphase = p;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r          <= '0;
			st_r.ld_state <= vpa_pkg::LD_IDLE;
			st_r.scheme   <= vpa_pkg::SEL_RESET;
			flow_r        <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			flow_r <= flow_init_pending_i;
		end
	end

	assign wb_dat_o      = st_r.rdat;
	assign wb_ack_o      = st_r.ack;
	assign grant_port_o  = st_r.grant;
	assign grant_phase_o = st_r.gphase;

	table_write_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && tbl_hit)
		|=> st_r.coherent)
		else $error("table write did not set coherency flag");

	flag_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.coherent && st_r.ld_state == vpa_pkg::LD_IDLE && !(wr && req.adr == vpa_pkg::OFS_CONTROL))
		|=> st_r.coherent)
		else $error("coherency flag cleared without load");

	downstream_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!is_upstream_i && access && !req.we && req.adr == vpa_pkg::OFS_STATUS)
		|=> !wb_dat_o[vpa_pkg::BIT_COHERENT])
		else $error("downstream coherency flag not zero");

	status_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && req.adr == vpa_pkg::OFS_STATUS)
		|=> wb_dat_o[31:18] == 14'h0000 && wb_dat_o[15:0] == 16'h0000)
		else $error("status reserved bits set");

	flow_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && req.adr == vpa_pkg::OFS_STATUS)
		|=> wb_dat_o[vpa_pkg::BIT_FLOWINIT] == $past(flow_r))
		else $error("flow init bit wrong");

	load_completes_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.ld_state == vpa_pkg::LD_COPY && st_r.ld_idx == 2'h0)
		|-> ##4 (st_r.ld_state == vpa_pkg::LD_IDLE || wr))
		else $error("table load did not finish");

	load_bit_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && req.adr == vpa_pkg::OFS_CONTROL)
		|=> !wb_dat_o[vpa_pkg::BIT_LOAD])
		else $error("load bit read back as one");

	grant_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(grant_port_o != vpa_pkg::GRANT_NONE)
		|-> port_of(slot_of(st_r.live, grant_phase_o)) == grant_port_o)
		else $error("grant not from phase");

	no_grant_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!uses_table($past(st_r.scheme))
		|-> grant_port_o == vpa_pkg::GRANT_NONE)
		else $error("grant outside scheme");

	ack_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		access
		|=> wb_ack_o)
		else $error("request not acknowledged");

	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o
		|=> !wb_ack_o)
		else $error("ack longer than one cycle");

	ack_only_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o
		|-> $past(access))
		else $error("ack without request");

	rdat_idle_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o
		|-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");

	grant_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$onehot0(grant_port_o))
		else $error("grant not one hot");

	no_grant_loading_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.ld_state == vpa_pkg::LD_COPY
		|=> grant_port_o == vpa_pkg::GRANT_NONE)
		else $error("grant during table load");

	load_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.ld_state == vpa_pkg::LD_COPY && st_r.ld_idx == 2'h3 && !(wr && tbl_hit))
		|=> !st_r.coherent)
		else $error("coherency flag not cleared after load");

	write_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.ld_state == vpa_pkg::LD_COPY && st_r.ld_idx == 2'h3 && wr && tbl_hit)
		|=> st_r.coherent)
		else $error("table write lost to load end");

	table_word_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && tbl_hit && req.sel == 4'hF)
		|=> st_r.tbl[$past(tbl_sel)] == $past(req.dat))
		else $error("table word not written");

	table_word_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && tbl_hit)
		|=> wb_dat_o == $past(st_r.tbl[tbl_sel]))
		else $error("table word read wrong");

	byte_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && tbl_hit && !req.sel[0])
		|=> st_r.tbl[$past(tbl_sel)][7:0] == $past(st_r.tbl[tbl_sel][7:0]))
		else $error("unselected byte changed");

	reset_slots_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i)
		|-> st_r.tbl == '0 && st_r.live == '0)
		else $error("phases not zero after reset");

	reset_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i)
		|-> !st_r.coherent && st_r.scheme == vpa_pkg::SEL_RESET)
		else $error("flag or scheme not reset");

	reset_grant_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i)
		|-> grant_port_o == vpa_pkg::GRANT_NONE)
		else $error("grant after reset");

	live_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.ld_state == vpa_pkg::LD_COPY
		|=> st_r.live[$past(st_r.ld_idx)] == $past(st_r.tbl[st_r.ld_idx]))
		else $error("live word not copied");

	live_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.ld_state == vpa_pkg::LD_IDLE
		|=> st_r.live == $past(st_r.live))
		else $error("live table changed without load");

	load_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && req.adr == vpa_pkg::OFS_CONTROL && req.sel[2] && req.dat[vpa_pkg::BIT_LOAD] && is_upstream_i)
		|=> st_r.ld_state == vpa_pkg::LD_COPY && st_r.ld_idx == 2'h0)
		else $error("load command not taken");

	load_down_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && req.adr == vpa_pkg::OFS_CONTROL && !is_upstream_i && st_r.ld_state == vpa_pkg::LD_IDLE)
		|=> st_r.ld_state == vpa_pkg::LD_IDLE)
		else $error("load started on downstream port");

	load_zero_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && req.adr == vpa_pkg::OFS_CONTROL && !req.dat[vpa_pkg::BIT_LOAD] && st_r.ld_state == vpa_pkg::LD_IDLE)
		|=> st_r.ld_state == vpa_pkg::LD_IDLE)
		else $error("load started by zero");

	scheme_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && req.adr == vpa_pkg::OFS_CONTROL && req.sel[2])
		|=> st_r.scheme == $past(req.dat[vpa_pkg::SEL_HI:vpa_pkg::SEL_LO]))
		else $error("scheme not written");

	control_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && req.adr == vpa_pkg::OFS_CONTROL)
		|=> wb_dat_o[vpa_pkg::SEL_HI:vpa_pkg::SEL_LO] == $past(st_r.scheme))
		else $error("scheme read back wrong");

	status_wr_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && req.adr == vpa_pkg::OFS_STATUS)
		|=> st_r.tbl == $past(st_r.tbl) && st_r.scheme == $past(st_r.scheme))
		else $error("status write had an effect");

	unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(access && !req.we && !tbl_hit && req.adr != vpa_pkg::OFS_STATUS && req.adr != vpa_pkg::OFS_CONTROL)
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	grant_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
		grant_port_o != vpa_pkg::GRANT_NONE
		|-> st_r.phase == 5'(st_r.gphase + 5'h1))
		else $error("phase pointer not past grant");

	skip_none_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(uses_table(st_r.scheme) && st_r.ld_state == vpa_pkg::LD_IDLE
		&& port_of(slot_of(st_r.live, st_r.phase)) != vpa_pkg::GRANT_NONE)
		|=> grant_phase_o == $past(st_r.phase))
		else $error("valid phase not granted at once");

	phase_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		grant_port_o == vpa_pkg::GRANT_NONE
		|-> st_r.phase == $past(st_r.phase))
		else $error("phase moved without grant");
endmodule

// >>> rtl/vpa_pkg.sv
// Purpose: shared constants and types for the vc port arbitration table block
// Assumes: 32-bit classic wishbone register access, byte addresses
// Notes:   table words 2 and 3 live at their own offsets beside words 0 and 1
package vpa_pkg;
	localparam logic [11:0] OFS_CONTROL  = 12'h214;
	localparam logic [11:0] OFS_STATUS   = 12'h218;
	localparam logic [11:0] OFS_TBL0     = 12'h220;
	localparam logic [11:0] OFS_TBL1     = 12'h224;
	localparam logic [11:0] OFS_TBL2     = 12'h228;
	localparam logic [11:0] OFS_TBL3     = 12'h22C;

	localparam int          NUM_PHASES   = 32;
	localparam int          NUM_WORDS    = 4;
	localparam int          SLOT_W       = 4;
	localparam int          SLOTS_PER_WD = 8;

	localparam int          BIT_LOAD     = 16;
	localparam int          SEL_LO       = 17;
	localparam int          SEL_HI       = 19;
	localparam int          BIT_COHERENT = 16;
	localparam int          BIT_FLOWINIT = 17;

	localparam logic [3:0]  PORT_UP      = 4'h0;
	localparam logic [3:0]  PORT_2       = 4'h2;
	localparam logic [3:0]  PORT_4       = 4'h4;
	localparam logic [3:0]  SLOT_RESET   = 4'h0;
	localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
	localparam logic [2:0]  SEL_RESET    = 3'h0;
	localparam logic [2:0]  GRANT_NONE   = 3'h0;
	localparam logic [2:0]  GRANT_UP     = 3'h1;
	localparam logic [2:0]  GRANT_P2     = 3'h2;
	localparam logic [2:0]  GRANT_P4     = 3'h4;
	localparam logic [7:0]  SCHEME_TBL_MASK = 8'hF8;

	typedef enum logic [0:0] {
		LD_IDLE,
		LD_COPY
	} vpa_load_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} vpa_wb_req_t;

	typedef struct packed {
		logic [NUM_WORDS-1:0][31:0] tbl;
		logic [NUM_WORDS-1:0][31:0] live;
		logic [2:0]                 scheme;
		logic                       coherent;
		vpa_load_state_t            ld_state;
		logic [1:0]                 ld_idx;
		logic [4:0]                 phase;
		logic [4:0]                 gphase;
		logic [2:0]                 grant;
		logic                       ack;
		logic [31:0]                rdat;
	} vpa_state_t;
endpackage
